// ### inc/fpe_pkg.sv
// ---------------------------------------------------------------------------
// fpe_pkg: shared constants and types of the flash program/erase sequencer
// ---------------------------------------------------------------------------
// holds timing figures, derived cycle counts, the mode-bit carrier and states.
// assumes a single 200 MHz core clock; counts round up for least waits.
package fpe_pkg;

  // ------------------------------------------------------------------------
  // clock
  // ------------------------------------------------------------------------
  localparam int unsigned CLK_PS = 5000;

  // ------------------------------------------------------------------------
  // wait times in ns, pulse totals in ms, as specified
  // ------------------------------------------------------------------------
  localparam int unsigned T_UNLOCK_NS = 1000;       // after write-unlock set
  localparam int unsigned T_PSETUP_NS = 50000;      // after program setup set
  localparam int unsigned T_PSHORT_NS = 30000;      // pulse, attempts 1..6
  localparam int unsigned T_PLONG_NS = 200000;      // pulse, attempts 7..1000
  localparam int unsigned T_PEXTRA_NS = 10000;      // additional pulse
  localparam int unsigned T_PPOFF_NS = 5000;        // after pulse clear
  localparam int unsigned T_PSOFF_NS = 5000;        // after setup clear
  localparam int unsigned T_PVON_NS = 4000;         // after verify set
  localparam int unsigned T_DUMMY_NS = 2000;        // after dummy write
  localparam int unsigned T_PVOFF_NS = 2000;        // after verify clear
  localparam int unsigned T_LOCKOFF_NS = 100000;    // after unlock clear
  localparam int unsigned T_ESETUP_NS = 100000;     // after erase setup set
  localparam int unsigned T_EPULSE_NS = 10000000;   // erase pulse, 10..100 ms
  localparam int unsigned T_EPOFF_NS = 10000;       // after erase pulse clear
  localparam int unsigned T_ESOFF_NS = 10000;       // after erase setup clear
  localparam int unsigned T_EVON_NS = 20000;        // after erase verify set
  localparam int unsigned T_EVOFF_NS = 4000;        // after erase verify clear
  localparam int unsigned T_PTOTAL_MS = 200;        // pulse total per unit
  localparam int unsigned T_ETOTAL_MS = 1200;       // pulse total per block

  // ------------------------------------------------------------------------
  // derived cycle counts (least waits round up)
  // ------------------------------------------------------------------------
  localparam int unsigned C_UNLOCK = (T_UNLOCK_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int unsigned C_PSETUP = (T_PSETUP_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int unsigned C_PSHORT = (T_PSHORT_NS * 1000) / CLK_PS;
  localparam int unsigned C_PLONG = (T_PLONG_NS * 1000) / CLK_PS;
  localparam int unsigned C_PEXTRA = (T_PEXTRA_NS * 1000) / CLK_PS;
  localparam int unsigned C_PPOFF = (T_PPOFF_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int unsigned C_PSOFF = (T_PSOFF_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int unsigned C_PVON = (T_PVON_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int unsigned C_DUMMY = (T_DUMMY_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int unsigned C_PVOFF = (T_PVOFF_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int unsigned C_LOCKOFF = (T_LOCKOFF_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int unsigned C_ESETUP = (T_ESETUP_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int unsigned C_EPULSE = (T_EPULSE_NS / CLK_PS) * 1000;
  localparam int unsigned C_EPOFF = (T_EPOFF_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int unsigned C_ESOFF = (T_ESOFF_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int unsigned C_EVON = (T_EVON_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int unsigned C_EVOFF = (T_EVOFF_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int unsigned C_PTOTAL = (T_PTOTAL_MS * 1000) * (1000000 / CLK_PS);
  localparam int unsigned C_ETOTAL = (T_ETOTAL_MS * 1000) * (1000000 / CLK_PS);

  // ------------------------------------------------------------------------
  // attempt limits and unit layout
  // ------------------------------------------------------------------------
  localparam logic [15:0] PROG_MAX_TRIES = 16'h03E8;  // 1000
  localparam logic [15:0] ERASE_MAX_TRIES = 16'h0078; // 120
  localparam logic [15:0] SHORT_LAST_TRY = 16'h0006;  // short pulse up to here
  localparam logic [15:0] PROG_UNIT_BYTES = 16'h0080; // 128
  localparam logic [7:0] ERASED_BYTE = 8'hFF;
  localparam logic [7:0] DUMMY_BYTE = 8'hFF;

  // ------------------------------------------------------------------------
  // flash mode control bits driven to the device
  // ------------------------------------------------------------------------
  typedef struct packed {
    logic flash_write_unlock_bit;
    logic program_setup_bit;
    logic program_pulse_bit;
    logic program_verify_bit;
    logic erase_setup_bit;
    logic erase_pulse_bit;
    logic erase_verify_bit;
  } fpe_mode_bits_type;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h0,
    ST_UNLOCK = 4'h1,
    ST_SETUP = 4'h2,
    ST_PULSE = 4'h3,
    ST_PULSE_OFF = 4'h4,
    ST_SETUP_OFF = 4'h5,
    ST_VFY_ON = 4'h6,
    ST_DUMMY = 4'h7,
    ST_DUMMY_WAIT = 4'h8,
    ST_READ = 4'h9,
    ST_COMPARE = 4'hA,
    ST_VFY_OFF = 4'hB,
    ST_LOCK_OFF = 4'hC
  } fpe_state_type;

endpackage

// ### hdl/fpe_sequencer.sv
// ---------------------------------------------------------------------------
// fpe_sequencer: program/erase timing sequencer for on-chip flash
// ---------------------------------------------------------------------------
// drives the flash mode control bits, dummy writes and verify reads.
// assumes device pins synchronous to core_clk, read data one cycle after strobe.
`timescale 1ns/1ps

module fpe_sequencer #(
  parameter int unsigned PSETUP_CYC = fpe_pkg::C_PSETUP,
  parameter int unsigned ESETUP_CYC = fpe_pkg::C_ESETUP,
  parameter int unsigned PSHORT_CYC = fpe_pkg::C_PSHORT,
  parameter int unsigned PLONG_CYC = fpe_pkg::C_PLONG,
  parameter int unsigned EPULSE_CYC = fpe_pkg::C_EPULSE,
  parameter int unsigned LOCKOFF_CYC = fpe_pkg::C_LOCKOFF,
  parameter int unsigned PTOTAL_CYC = fpe_pkg::C_PTOTAL,
  parameter int unsigned ETOTAL_CYC = fpe_pkg::C_ETOTAL,
  parameter logic [15:0] ERASE_BYTES = 16'h0080
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // user command side
  input wire logic start_program,
  input wire logic start_erase,
  input wire logic [15:0] base_addr,
  input wire logic [7:0] expect_byte,
  output logic [15:0] verify_index,
  output logic busy,
  output logic done,
  output logic failed,
  output logic [15:0] attempts,
  // device side
  output fpe_pkg::fpe_mode_bits_type mode_bits,
  output logic mem_wr,
  output logic mem_rd,
  output logic [15:0] mem_addr,
  output logic [7:0] mem_wdata,
  input wire logic [7:0] mem_rdata
);

  // ------------------------------------------------------------------------
  // state and working registers
  // ------------------------------------------------------------------------
  fpe_pkg::fpe_state_type state_q, state_d;
  logic erase_q;
  logic extra_q, extra_d;
  logic [15:0] tries_q, tries_d;
  logic [31:0] timer_q;
  logic [31:0] total_q;
  logic [15:0] idx_q;
  logic bad_q;
  logic fail_q, fail_d;
  logic done_q;
  logic [31:0] cur_len;
  logic [31:0] next_len;
  logic fits;
  logic last_byte;
  logic timer_zero;

  assign timer_zero = (timer_q == 32'h0000_0000);
  assign last_byte = erase_q ? (idx_q == ERASE_BYTES - 16'h0001)
                             : (idx_q == fpe_pkg::PROG_UNIT_BYTES - 16'h0001);

  // pulse length for a given attempt number and extra-pulse flag
  function automatic logic [31:0] pulse_len(input logic er, input logic [15:0] n,
                                            input logic ex);
    if (er) begin
      pulse_len = EPULSE_CYC;
    end else if (ex) begin
      pulse_len = fpe_pkg::C_PEXTRA;
    end else if (n <= fpe_pkg::SHORT_LAST_TRY) begin
      pulse_len = PSHORT_CYC;
    end else begin
      pulse_len = PLONG_CYC;
    end
  endfunction

  // time spent in each state; dummy, read and compare are single cycles
  function automatic logic [31:0] dwell(input fpe_pkg::fpe_state_type st,
                                        input logic er, input logic [31:0] plen);
    unique case (st)
      fpe_pkg::ST_UNLOCK: dwell = fpe_pkg::C_UNLOCK;
      fpe_pkg::ST_SETUP: dwell = er ? ESETUP_CYC : PSETUP_CYC;
      fpe_pkg::ST_PULSE: dwell = plen;
      fpe_pkg::ST_PULSE_OFF: dwell = er ? fpe_pkg::C_EPOFF : fpe_pkg::C_PPOFF;
      fpe_pkg::ST_SETUP_OFF: dwell = er ? fpe_pkg::C_ESOFF : fpe_pkg::C_PSOFF;
      fpe_pkg::ST_VFY_ON: dwell = er ? fpe_pkg::C_EVON : fpe_pkg::C_PVON;
      fpe_pkg::ST_DUMMY_WAIT: dwell = fpe_pkg::C_DUMMY;
      fpe_pkg::ST_VFY_OFF: dwell = er ? fpe_pkg::C_EVOFF : fpe_pkg::C_PVOFF;
      fpe_pkg::ST_LOCK_OFF: dwell = LOCKOFF_CYC;
      default: dwell = 32'h0000_0001;
    endcase
  endfunction

  assign cur_len = pulse_len(erase_q, tries_q, extra_q);
  // length of the pulse a retry or extra pass would use; from registers only,
  // so the budget decision below cannot feed back into itself
  assign next_len = pulse_len(erase_q, bad_q ? tries_q + 16'h0001 : tries_q, !bad_q);
  // a further pulse must keep the running total inside the budget
  assign fits = ({1'b0, total_q} + {1'b0, next_len})
                <= {1'b0, (erase_q ? ETOTAL_CYC : PTOTAL_CYC)};

  // ------------------------------------------------------------------------
  // next-state decision
  // ------------------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    tries_d = tries_q;
    extra_d = extra_q;
    fail_d = fail_q;
    unique case (state_q)
      fpe_pkg::ST_IDLE: begin
        if (start_program || start_erase) begin
          state_d = fpe_pkg::ST_UNLOCK;
          tries_d = 16'h0001;
          extra_d = 1'b0;
          fail_d = 1'b0;
        end
      end
      fpe_pkg::ST_UNLOCK: begin
        if (timer_zero) begin
          state_d = fpe_pkg::ST_SETUP;
        end
      end
      fpe_pkg::ST_SETUP: if (timer_zero) state_d = fpe_pkg::ST_PULSE;
      fpe_pkg::ST_PULSE: if (timer_zero) state_d = fpe_pkg::ST_PULSE_OFF;
      fpe_pkg::ST_PULSE_OFF: if (timer_zero) state_d = fpe_pkg::ST_SETUP_OFF;
      fpe_pkg::ST_SETUP_OFF: if (timer_zero) state_d = fpe_pkg::ST_VFY_ON;
      fpe_pkg::ST_VFY_ON: if (timer_zero) state_d = fpe_pkg::ST_DUMMY;
      fpe_pkg::ST_DUMMY: state_d = fpe_pkg::ST_DUMMY_WAIT;
      fpe_pkg::ST_DUMMY_WAIT: if (timer_zero) state_d = fpe_pkg::ST_READ;
      fpe_pkg::ST_READ: state_d = fpe_pkg::ST_COMPARE;
      fpe_pkg::ST_COMPARE: begin
        state_d = last_byte ? fpe_pkg::ST_VFY_OFF : fpe_pkg::ST_DUMMY;
      end
      fpe_pkg::ST_VFY_OFF: begin
        if (timer_zero) begin
          if (extra_q || (!bad_q && erase_q)) begin
            state_d = fpe_pkg::ST_LOCK_OFF;
          end else if (!bad_q) begin
            // early success earns one short reinforcing pulse
            if (tries_q <= fpe_pkg::SHORT_LAST_TRY) begin
              extra_d = 1'b1;
              state_d = fpe_pkg::ST_SETUP;
            end else begin
              state_d = fpe_pkg::ST_LOCK_OFF;
            end
          end else if (tries_q == (erase_q ? fpe_pkg::ERASE_MAX_TRIES
                                           : fpe_pkg::PROG_MAX_TRIES)) begin
            fail_d = 1'b1;
            state_d = fpe_pkg::ST_LOCK_OFF;
          end else begin
            tries_d = tries_q + 16'h0001;
            state_d = fpe_pkg::ST_SETUP;
          end
          // refuse a pulse that would break the total budget
          if ((state_d == fpe_pkg::ST_SETUP) && !fits) begin
            fail_d = 1'b1;
            tries_d = tries_q;
            extra_d = extra_q;
            state_d = fpe_pkg::ST_LOCK_OFF;
          end
        end
      end
      fpe_pkg::ST_LOCK_OFF: if (timer_zero) state_d = fpe_pkg::ST_IDLE;
      default: state_d = fpe_pkg::ST_IDLE;
    endcase
  end

  // ------------------------------------------------------------------------
  // state, attempt and flag registers
  // ------------------------------------------------------------------------
  // state and attempt bookkeeping
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= fpe_pkg::ST_IDLE;
      tries_q <= 16'h0000;
      extra_q <= 1'b0;
      fail_q <= 1'b0;
      erase_q <= 1'b0;
    end else begin
      state_q <= state_d;
      tries_q <= tries_d;
      extra_q <= extra_d;
      fail_q <= fail_d;
      if (state_q == fpe_pkg::ST_IDLE && state_d == fpe_pkg::ST_UNLOCK) begin
        erase_q <= !start_program; // program wins if both are asked
      end
    end
  end

  // one dwell timer, reloaded on every state change
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      timer_q <= 32'h0000_0000;
    end else if (state_d != state_q) begin
      timer_q <= dwell(state_d, (state_q == fpe_pkg::ST_IDLE) ? !start_program : erase_q,
                       cur_len) - 32'h0000_0001;
    end else if (!timer_zero) begin
      timer_q <= timer_q - 32'h0000_0001;
    end
  end

  // running pulse total, excluding verify time
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      total_q <= 32'h0000_0000;
    end else if (state_q == fpe_pkg::ST_IDLE) begin
      total_q <= 32'h0000_0000;
    end else if (state_q == fpe_pkg::ST_PULSE && timer_zero) begin
      total_q <= total_q + cur_len;
    end
  end

  // byte walk and mismatch flag over the verify pass
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      idx_q <= 16'h0000;
      bad_q <= 1'b0;
    end else if (state_q == fpe_pkg::ST_VFY_ON) begin
      idx_q <= 16'h0000;
      bad_q <= 1'b0;
    end else if (state_q == fpe_pkg::ST_COMPARE) begin
      idx_q <= idx_q + 16'h0001;
      if (mem_rdata != (erase_q ? fpe_pkg::ERASED_BYTE : expect_byte)) begin
        bad_q <= 1'b1;
      end
    end
  end

  // ------------------------------------------------------------------------
  // device-facing outputs, registered from the next state
  // ------------------------------------------------------------------------
  // bits follow the state; erase flavour chosen by the latched mode
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      mode_bits <= '0;
      mem_wr <= 1'b0;
      mem_rd <= 1'b0;
      mem_addr <= 16'h0000;
      done_q <= 1'b0;
    end else begin
      mode_bits <= '0;
      mode_bits.flash_write_unlock_bit <= (state_d != fpe_pkg::ST_IDLE)
                                          && (state_d != fpe_pkg::ST_LOCK_OFF);
      if (state_d == fpe_pkg::ST_SETUP || state_d == fpe_pkg::ST_PULSE
          || state_d == fpe_pkg::ST_PULSE_OFF) begin
        mode_bits.program_setup_bit <= !erase_q;
        mode_bits.erase_setup_bit <= erase_q;
      end
      if (state_d == fpe_pkg::ST_PULSE) begin
        mode_bits.program_pulse_bit <= !erase_q;
        mode_bits.erase_pulse_bit <= erase_q;
      end
      if (state_d == fpe_pkg::ST_VFY_ON || state_d == fpe_pkg::ST_DUMMY
          || state_d == fpe_pkg::ST_DUMMY_WAIT || state_d == fpe_pkg::ST_READ
          || state_d == fpe_pkg::ST_COMPARE) begin
        mode_bits.program_verify_bit <= !erase_q;
        mode_bits.erase_verify_bit <= erase_q;
      end
      mem_wr <= (state_d == fpe_pkg::ST_DUMMY);
      mem_rd <= (state_d == fpe_pkg::ST_READ);
      mem_addr <= base_addr + ((state_q == fpe_pkg::ST_COMPARE) ? idx_q + 16'h0001 : idx_q);
      done_q <= (state_q == fpe_pkg::ST_LOCK_OFF) && timer_zero;
    end
  end

  assign mem_wdata = fpe_pkg::DUMMY_BYTE;
  assign verify_index = idx_q;
  assign busy = (state_q != fpe_pkg::ST_IDLE);
  assign done = done_q;
  assign failed = fail_q;
  assign attempts = tries_q;

  // ------------------------------------------------------------------------
  // checks
  // ------------------------------------------------------------------------
  // cycles the mode bits have stood unchanged, for spacing checks
  logic [31:0] hold_q;
  logic [31:0] pulse_run_q;
  logic [31:0] since_wr_q;
  fpe_pkg::fpe_mode_bits_type mode_prev_q;
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      hold_q <= 32'h0000_0000;
      pulse_run_q <= 32'h0000_0000;
      since_wr_q <= 32'h0000_0000;
      mode_prev_q <= '0;
    end else begin
      mode_prev_q <= mode_bits;
      hold_q <= (mode_bits != mode_prev_q) ? 32'h0000_0001 : hold_q + 32'h0000_0001;
      pulse_run_q <= mode_bits.erase_pulse_bit ? pulse_run_q + 32'h0000_0001 : 32'h0000_0000;
      since_wr_q <= mem_wr ? 32'h0000_0001 : since_wr_q + 32'h0000_0001;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);

  psetup_wait_a: assert property ($rose(mode_bits.program_pulse_bit)
    |-> hold_q >= PSETUP_CYC) else $error("program pulse set too soon");
  ppulse_len_a: assert property ($fell(mode_bits.program_pulse_bit)
    |-> hold_q == PSHORT_CYC || hold_q == PLONG_CYC || hold_q == fpe_pkg::C_PEXTRA)
    else $error("program pulse width wrong");
  pulse_choice_a: assert property ($fell(mode_bits.program_pulse_bit) && !extra_q
    && tries_q >= 16'h0007 |-> hold_q == PLONG_CYC)
    else $error("late attempt used short pulse");
  ppoff_wait_a: assert property ($fell(mode_bits.program_setup_bit)
    |-> hold_q >= fpe_pkg::C_PPOFF) else $error("setup cleared too soon");
  vfy_gap_a: assert property ($rose(mode_bits.program_verify_bit)
    |-> hold_q >= fpe_pkg::C_PSOFF) else $error("verify set too soon");
  dummy_read_a: assert property (mem_rd |-> since_wr_q >= fpe_pkg::C_DUMMY)
    else $error("read follows dummy write too soon");
  tries_cap_a: assert property (busy |-> tries_q <= fpe_pkg::PROG_MAX_TRIES)
    else $error("attempt count over cap");
  ptotal_a: assert property (busy && !erase_q |-> total_q <= PTOTAL_CYC)
    else $error("program pulse budget exceeded");
  esetup_wait_a: assert property ($rose(mode_bits.erase_pulse_bit)
    |-> hold_q >= ESETUP_CYC) else $error("erase pulse set too soon");
  epulse_max_a: assert property (pulse_run_q <= EPULSE_CYC)
    else $error("erase pulse too long");
  etries_cap_a: assert property (busy && erase_q |-> tries_q <= fpe_pkg::ERASE_MAX_TRIES)
    else $error("erase attempts over cap");
  unlock_first_a: assert property ($rose(mode_bits.flash_write_unlock_bit)
    |-> !(mode_bits.program_setup_bit || mode_bits.erase_setup_bit) [*8])
    else $error("setup set right after unlock");
  fail_done_a: assert property (done && failed |-> !busy && $past(state_q) ==
    fpe_pkg::ST_LOCK_OFF) else $error("failure reported out of place");

  prog_pass_c: cover property (done && !failed && !erase_q);
  erase_pass_c: cover property (done && !failed && erase_q);
  retry_c: cover property (tries_q == 16'h0002 && mode_bits.program_pulse_bit);
  fail_c: cover property (done && failed);

endmodule

// ### verif/fpe_flash_model.sv
// fpe_flash_model: behavioural flash block on the far side of the sequencer
// assumes read data is wanted exactly one cycle after mem_rd
`timescale 1ns/1ps
module fpe_flash_model (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // sequencer side
  input wire fpe_pkg::fpe_mode_bits_type mode_bits,
  input wire logic mem_rd,
  output logic [7:0] mem_rdata,
  // erase pulses the block needs before it reads blank
  input wire logic [7:0] need_pulses
);
  logic [7:0] pulses_q;
  logic ep_q;
  // count erase pulses; a fresh unlock starts a new block count
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      pulses_q <= 8'h00;
      ep_q <= 1'b0;
    end else begin
      ep_q <= mode_bits.erase_pulse_bit;
      if (!mode_bits.flash_write_unlock_bit) pulses_q <= 8'h00;
      else if (mode_bits.erase_pulse_bit && !ep_q) pulses_q <= pulses_q + 8'h01;
    end
  end
  // read port: blank after enough pulses, 8'h00 before; data inverts every cycle without a read
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) mem_rdata <= 8'h00;
    else if (mem_rd) mem_rdata <= (pulses_q >= need_pulses) ? fpe_pkg::ERASED_BYTE : 8'h00;
    else mem_rdata <= ~mem_rdata;
  end
endmodule

// ### verif/tb.sv
// tb: directed scenarios for the program/erase sequencer
// assumes shortened erase setup, pulse and budget, lock-off and a four-byte block; all other waits run full size
`timescale 1ns/1ps
module tb;
  logic core_clk = 1'b0, rst_b = 1'b0, start_program = 1'b0, start_erase = 1'b0;
  logic [15:0] base_addr = 16'h1200;
  logic [7:0] expect_byte = 8'h5A, need = 8'h02, mem_rdata;
  logic [15:0] verify_index, attempts, mem_addr;
  logic busy, done, failed, mem_wr, mem_rd, ep_q = 1'b0;
  logic [7:0] mem_wdata;
  fpe_pkg::fpe_mode_bits_type mode_bits;
  logic [8:0] sig;
  int n_errors = 0, n_tests = 0, n, ecyc = 0, epul = 0;
  assign sig = {mode_bits, mem_wr, mem_rd};
  always #2.5 core_clk = ~core_clk;
  fpe_sequencer #(.ESETUP_CYC(30), .EPULSE_CYC(50), .LOCKOFF_CYC(25), .ETOTAL_CYC(150),
    .ERASE_BYTES(16'h0004)) dut (.core_clk(core_clk), .rst_b(rst_b),
    .start_program(start_program), .start_erase(start_erase), .base_addr(base_addr),
    .expect_byte(expect_byte), .verify_index(verify_index), .busy(busy), .done(done),
    .failed(failed), .attempts(attempts), .mode_bits(mode_bits), .mem_wr(mem_wr),
    .mem_rd(mem_rd), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata));
  fpe_flash_model flash (.core_clk(core_clk), .rst_b(rst_b), .mode_bits(mode_bits),
    .mem_rd(mem_rd), .mem_rdata(mem_rdata), .need_pulses(need));
  // erase pulse time and pulse count since the last erase start
  always @(posedge core_clk) begin
    ep_q <= mode_bits.erase_pulse_bit;
    if (start_erase) begin
      ecyc <= 0;
      epul <= 0;
    end else begin
      if (mode_bits.erase_pulse_bit === 1'b1) ecyc <= ecyc + 1;
      if (mode_bits.erase_pulse_bit === 1'b1 && ep_q === 1'b0) epul <= epul + 1;
    end
  end
  task automatic wrap_up;
    $display("errors %0d of %0d checks", n_errors, n_tests);
    if (n_errors == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input logic ok, input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (ok !== 1'b1) begin
      n_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // edges until sig[b] reads v; bounded so a stuck sequencer ends the run
  task automatic wait_bit(input int b, input logic v, output int cyc);
    cyc = 0;
    while (sig[b] !== v && cyc < 60000) begin
      @(posedge core_clk);
      #1;
      cyc++;
    end
    if (cyc >= 60000) begin
      n_errors++;
      wrap_up();
    end
  endtask
  task automatic go(input logic prog);
    @(posedge core_clk);
    start_program <= prog;
    start_erase <= !prog;
    @(posedge core_clk);
    start_program <= 1'b0;
    start_erase <= 1'b0;
    #1;
  endtask
  // first program attempt timed step by step, then cut off by a reset
  task automatic prog_abort;
    go(1'b1);
    wait_bit(8, 1'b1, n);
    wait_bit(7, 1'b1, n);
    chk(n >= fpe_pkg::C_UNLOCK, n, fpe_pkg::C_UNLOCK);
    wait_bit(6, 1'b1, n);
    chk(n >= fpe_pkg::C_PSETUP, n, fpe_pkg::C_PSETUP);
    wait_bit(6, 1'b0, n);
    chk(n == fpe_pkg::C_PSHORT, n, fpe_pkg::C_PSHORT);
    wait_bit(7, 1'b0, n);
    chk(n >= fpe_pkg::C_PPOFF, n, fpe_pkg::C_PPOFF);
    wait_bit(5, 1'b1, n);
    chk(n >= fpe_pkg::C_PSOFF, n, fpe_pkg::C_PSOFF);
    wait_bit(1, 1'b1, n);
    chk(n >= fpe_pkg::C_PVON, n, fpe_pkg::C_PVON);
    chk(mem_addr === base_addr && mem_wdata === 8'hFF, mem_addr, base_addr);
    wait_bit(0, 1'b1, n);
    chk(n >= fpe_pkg::C_DUMMY, n, fpe_pkg::C_DUMMY);
    @(posedge core_clk);
    rst_b <= 1'b0;
    @(posedge core_clk);
    #1;
    chk(mode_bits === 7'h00 && busy === 1'b0, mode_bits, 7'h00);
    repeat (3) @(posedge core_clk);
    rst_b <= 1'b1;
  endtask
  // erase until blank or out of budget; first attempt timed in detail
  task automatic erase_run(input logic [7:0] pulses, input logic fail);
    @(posedge core_clk);
    need <= pulses;
    go(1'b0);
    wait_bit(4, 1'b1, n);
    wait_bit(3, 1'b1, n);
    chk(n >= 30, n, 30);
    wait_bit(3, 1'b0, n);
    chk(n == 50, n, 50);
    wait_bit(4, 1'b0, n);
    chk(n >= fpe_pkg::C_EPOFF, n, fpe_pkg::C_EPOFF);
    wait_bit(2, 1'b1, n);
    chk(n >= fpe_pkg::C_ESOFF, n, fpe_pkg::C_ESOFF);
    wait_bit(1, 1'b1, n);
    chk(n >= fpe_pkg::C_EVON, n, fpe_pkg::C_EVON);
    // first verify always misses, so the block is set up again after the gap
    wait_bit(2, 1'b0, n);
    wait_bit(4, 1'b1, n);
    chk(n >= fpe_pkg::C_EVOFF, n, fpe_pkg::C_EVOFF);
    n = 0;
    while (done !== 1'b1 && n < 90000) begin
      @(posedge core_clk);
      #1;
      n++;
    end
    if (n >= 90000) begin
      n_errors++;
      wrap_up();
    end
    chk(done === 1'b1 && failed === fail, failed, fail);
    chk(verify_index === 16'h0004, verify_index, 16'h0004);
    chk(ecyc <= 150 && epul <= 3, ecyc, 150);
    chk(fail || attempts === 16'(pulses), attempts, pulses);
    chk(attempts === 16'(epul), attempts, epul);
  endtask
  initial begin
    repeat (3) @(posedge core_clk);
    rst_b <= 1'b1;
    prog_abort();
    erase_run(8'h02, 1'b0);
    erase_run(8'h63, 1'b1);
    wrap_up();
  end
endmodule
